//--- wwd_pkg.sv
// wwd_pkg: constants for the window watchdog timer.
// assumes slow oscillator ticks arrive as a level input sampled on clk_i.
package wwd_pkg;
	localparam int          CFG_W        = 8;
	localparam int          CODE_W       = 4;
	localparam int          CNT_W        = 14;
	localparam int          PERIOD_LSB   = 0;
	localparam int          WINDOW_LSB   = 4;
	localparam logic [3:0]  CODE_OFF     = 4'h0;
	localparam logic [3:0]  CODE_MAX     = 4'hB;
	localparam logic [13:0] SPAN_BASE    = 14'h0008;
	localparam logic [1:0]  SYNC_TICKS   = 2'h2;
	localparam real         SLOW_CLK_KHZ = 1.024;
	localparam logic [7:0]  CFG_RESET    = 8'h00;

	typedef enum logic [2:0] {
		PH_IDLE   = 3'b001,
		PH_CLOSED = 3'b010,
		PH_OPEN   = 3'b100
	} wwd_phase_e;

	// slow-clock cycles selected by a span code; reserved codes clamp to the longest
	function automatic logic [13:0] wwd_span(input logic [3:0] code);
		logic [3:0] c;
		c = (code > CODE_MAX) ? CODE_MAX : code;
		return (code == CODE_OFF) ? 14'h0000 : 14'(SPAN_BASE << (c - 4'h1));
	endfunction
endpackage

//--- wwd_top.sv
// wwd_top: window watchdog with protected configuration, lock and clear synchronisation.
// assumes slow_osc_clock_i is a 1.024 kHz level synchronous to clk_i; fuse is stable at reset release.
`timescale 1ns/1ps
// Function
// - expiry without clear raises reset request
// - clear requests, open-period expiry and debug mode restart the counter
// - window mode clear outside slot resets
// - counts outside debug mode, slow clock only
// - nonzero timeout field enables, zero disables
// - nonzero closed-span field selects window mode
// - config and lock need unlocked writes
// - config from fuse, enabled fuse sets lock
// - counter advances on slow oscillator ticks
// - config writes take effect after sync
// - accepted clear restarts from zero
// - eleven timeout periods, 8 ms to 8 s
// - closed-span zero means normal mode
// - closed slot precedes open; early clear resets
// - codes 1..B select 8..8K cycles
// - lock set-only, blocks config, debug clears
// - clear syncs two ticks, extras ignored
module wwd_top
	import wwd_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       slow_osc_clock_i,
	input  wire logic       watchdog_clear_instruction_i,
	input  wire logic       protected_write_unlock_i,
	input  wire logic       cfg_wr_i,
	input  wire logic [7:0] cfg_wdata_i,
	input  wire logic       lock_wr_i,
	input  wire logic       lock_wdata_i,
	input  wire logic       debug_mode_i,
	input  wire logic [7:0] boot_config_fuse_i,
	output logic      [7:0] watchdog_config_o,
	output logic            lock_o,
	output logic            sync_pending_o,
	output logic            sys_reset_req_o
);
	logic             boot_done_q;
	logic [7:0]       cfg_q;
	logic [7:0]       act_cfg_q;
	logic             lock_q;
	logic             osc_q;
	logic             tick;
	logic             cfg_pend_q;
	logic [1:0]       cfg_cnt_q;
	logic             clr_pend_q;
	logic [1:0]       clr_cnt_q;
	logic             clr_apply;
	logic             cfg_take;
	logic             boot_load;
	logic [13:0]      cnt_q;
	logic [13:0]      open_lim;
	logic [13:0]      closed_lim;
	logic             enabled;
	logic             rst_pulse_q;
	wwd_phase_e       phase_q;

	assign boot_load = !boot_done_q;
	assign tick      = slow_osc_clock_i && !osc_q;
	assign cfg_take  = boot_done_q && cfg_wr_i && protected_write_unlock_i && !lock_q && !cfg_pend_q;
	assign clr_apply = clr_pend_q && tick && (clr_cnt_q == SYNC_TICKS - 2'h1);
	assign open_lim  = wwd_span(act_cfg_q[PERIOD_LSB +: CODE_W]);
	assign closed_lim = wwd_span(act_cfg_q[WINDOW_LSB +: CODE_W]);
	assign enabled   = act_cfg_q[PERIOD_LSB +: CODE_W] != CODE_OFF;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			boot_done_q <= 1'b0;
			osc_q       <= 1'b0;
		end else begin
			boot_done_q <= 1'b1;
			osc_q       <= slow_osc_clock_i;
		end
	end

	// configuration register as software sees it
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_q <= CFG_RESET;
		end else if (boot_load) begin
			cfg_q <= boot_config_fuse_i;
		end else if (cfg_take) begin
			cfg_q <= cfg_wdata_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lock_q <= 1'b0;
		end else if (boot_load) begin
			lock_q <= boot_config_fuse_i[PERIOD_LSB +: CODE_W] != CODE_OFF;
		end else if (lock_wr_i && protected_write_unlock_i) begin
			if (lock_wdata_i) begin
				lock_q <= 1'b1;
			end else if (debug_mode_i) begin
				lock_q <= 1'b0;
			end
		end
	end

	// write crosses into the slow domain over two ticks
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_pend_q <= 1'b0;
			cfg_cnt_q  <= 2'h0;
			act_cfg_q  <= CFG_RESET;
		end else if (boot_load) begin
			act_cfg_q <= boot_config_fuse_i;
		end else if (cfg_take) begin
			cfg_pend_q <= 1'b1;
			cfg_cnt_q  <= 2'h0;
		end else if (cfg_pend_q && tick) begin
			if (cfg_cnt_q == SYNC_TICKS - 2'h1) begin
				cfg_pend_q <= 1'b0;
				act_cfg_q  <= cfg_q;
			end else begin
				cfg_cnt_q <= cfg_cnt_q + 2'h1;
			end
		end
	end

	// clear request synchroniser; a clear while one is pending is dropped
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			clr_pend_q <= 1'b0;
			clr_cnt_q  <= 2'h0;
		end else if (!clr_pend_q) begin
			clr_pend_q <= watchdog_clear_instruction_i;
			clr_cnt_q  <= 2'h0;
		end else if (tick) begin
			if (clr_apply) begin
				clr_pend_q <= 1'b0;
			end else begin
				clr_cnt_q <= clr_cnt_q + 2'h1;
			end
		end
	end

	// phase and counter run off slow ticks only; debug mode holds them at the start of the open phase
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase_q     <= PH_IDLE;
			cnt_q       <= 14'h0000;
			rst_pulse_q <= 1'b0;
		end else begin
			rst_pulse_q <= 1'b0;
			if (!enabled) begin
				phase_q <= PH_IDLE;
				cnt_q   <= 14'h0000;
			end else if (debug_mode_i || phase_q == PH_IDLE) begin
				phase_q <= PH_OPEN;                                                    // first closed slot waits for a clear
				cnt_q   <= 14'h0000;
			end else if (clr_apply) begin
				cnt_q <= 14'h0000;
				if (phase_q == PH_CLOSED) begin
					rst_pulse_q <= 1'b1;
					phase_q     <= PH_OPEN;
				end else if (closed_lim != 14'h0000) begin
					phase_q <= PH_CLOSED;
				end else begin
					phase_q <= PH_OPEN;
				end
			end else if (tick) begin
				if (phase_q == PH_CLOSED && cnt_q == closed_lim - 14'h0001) begin
					phase_q <= PH_OPEN;
					cnt_q   <= 14'h0000;
				end else if (phase_q == PH_OPEN && cnt_q == open_lim - 14'h0001) begin
					rst_pulse_q <= 1'b1;
					cnt_q       <= 14'h0000;
				end else begin
					cnt_q <= cnt_q + 14'h0001;
				end
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			watchdog_config_o <= CFG_RESET;
			lock_o            <= 1'b0;
			sync_pending_o    <= 1'b0;
			sys_reset_req_o   <= 1'b0;
		end else begin
			watchdog_config_o <= cfg_q;
			lock_o            <= lock_q;
			sync_pending_o    <= cfg_pend_q;
			sys_reset_req_o   <= rst_pulse_q;
		end
	end

	sequence open_expiry_s;
		enabled && !debug_mode_i && !clr_apply && phase_q == PH_OPEN && tick && cnt_q == open_lim - 14'h0001;
	endsequence
	sequence early_clear_s;
		enabled && !debug_mode_i && clr_apply && phase_q == PH_CLOSED;
	endsequence

	timeout_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
		open_expiry_s |=> rst_pulse_q ##1 sys_reset_req_o)
		else $error("no reset after open period expired");
	early_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		early_clear_s |=> rst_pulse_q && phase_q == PH_OPEN)
		else $error("clear in closed slot did not reset");
	cfg_protect_a: assert property (@(posedge clk_i) disable iff (rst_i)
		boot_done_q && !(cfg_wr_i && protected_write_unlock_i) |=> $stable(cfg_q))
		else $error("config changed without unlocked write");
	lock_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
		boot_done_q && lock_q |=> $stable(cfg_q))
		else $error("config changed while locked");
	lock_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
		boot_done_q && lock_q && !debug_mode_i |=> lock_q)
		else $error("lock cleared outside debug");
	fuse_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
		boot_load && boot_config_fuse_i[3:0] != 4'h0 |=> lock_q && cfg_q == $past(boot_config_fuse_i))
		else $error("enabled fuse did not set lock");
	sync_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_take |=> cfg_pend_q ##1 sync_pending_o)
		else $error("sync pending not raised after write");
	clear_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
		enabled && !debug_mode_i && phase_q == PH_OPEN && clr_apply |=> cnt_q == 14'h0000 && !rst_pulse_q)
		else $error("accepted clear did not restart count");
	clear_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		clr_pend_q && !clr_apply |=> clr_pend_q && $past(clr_cnt_q) <= clr_cnt_q)
		else $error("pending clear disturbed");
	single_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sys_reset_req_o |=> !sys_reset_req_o)
		else $error("reset request longer than one cycle");
	idle_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!enabled |=> !rst_pulse_q && phase_q == PH_IDLE)
		else $error("disabled watchdog active");
	span_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
		enabled && act_cfg_q[PERIOD_LSB +: CODE_W] <= CODE_MAX
			|-> open_lim == (14'h0001 << (act_cfg_q[PERIOD_LSB +: CODE_W] + 4'h2)))
		else $error("span decode wrong");
endmodule

//--- wwd_cpu_model.sv
// wwd_cpu_model: cpu side issuing clear instructions and reset controller counting resets.
// assumes go_i is driven by the bench on the falling edge, one cycle per clear; rst_i clears the tally.
`timescale 1ns/1ps
module wwd_cpu_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       go_i,
	input  wire logic       sys_reset_req_i,
	output logic            clear_o,
	output logic      [7:0] resets_o
);
	// each executed clear instruction reaches the watchdog as one request
	assign clear_o = go_i;
	// reset controller tally of requests seen
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			resets_o <= 8'h00;
		end else if (sys_reset_req_i === 1'b1) begin
			resets_o <= resets_o + 8'h01;
		end
	end
endmodule

//--- wwd_top_test.sv
// wwd_top_test: directed checks of the window watchdog through its strobes.
// assumes the slow oscillator is sped up to one tick per 8 clk to keep the run short.
`timescale 1ns/1ps
module wwd_top_test;
	import wwd_pkg::*;
	logic       clk_i   = 1'b0;
	logic       rst_i   = 1'b1;
	logic       slow    = 1'b0;
	logic       go      = 1'b0;
	logic       unl     = 1'b0;
	logic       cfg_wr  = 1'b0;
	logic       lock_wr = 1'b0;
	logic       lock_d  = 1'b0;
	logic       dbg     = 1'b0;
	logic [7:0] fuse    = 8'h00;
	logic [7:0] wdata   = 8'h00;
	logic       clr;
	logic [7:0] cfg_o;
	logic       lock_o;
	logic       pend;
	logic       rreq;
	logic [7:0] resets;
	logic [7:0] base;
	int         error_cnt = 0;
	int         compares  = 0;

	wwd_top DUT (.clk_i(clk_i), .rst_i(rst_i), .slow_osc_clock_i(slow), .watchdog_clear_instruction_i(clr),
		.protected_write_unlock_i(unl), .cfg_wr_i(cfg_wr), .cfg_wdata_i(wdata), .lock_wr_i(lock_wr),
		.lock_wdata_i(lock_d), .debug_mode_i(dbg), .boot_config_fuse_i(fuse), .watchdog_config_o(cfg_o),
		.lock_o(lock_o), .sync_pending_o(pend), .sys_reset_req_o(rreq));
	wwd_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .sys_reset_req_i(rreq), .clear_o(clr),
		.resets_o(resets));

	initial forever #2.5 clk_i = ~clk_i;
	// toggles on falling edges of clk_i
	initial forever #20 slow = ~slow;

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// rst_mode 1: wait for a reset pulse, 0: wait for sync to finish
	task automatic waitfor(input bit rst_mode);
		for (int i = 0; i < 400; i++) begin
			if (rst_mode ? rreq === 1'b1 : pend === 1'b0) return;
			@(negedge clk_i);
		end
		error_cnt++;
		conclude();
	endtask

	task automatic put(input logic c, input logic l, input logic u, input logic [7:0] d);
		cfg_wr = c;
		lock_wr = l;
		unl = u;
		wdata = d;
		lock_d = d[0];
		@(negedge clk_i);
		cfg_wr = 1'b0;
		lock_wr = 1'b0;
		unl = 1'b0;
		repeat (3) @(negedge clk_i);
	endtask

	task automatic clear(input int gap);
		go = 1'b1;
		@(negedge clk_i);
		go = 1'b0;
		repeat (gap - 1) @(negedge clk_i);
	endtask

	initial begin
		repeat (8) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (3) @(negedge clk_i);
		check("boot config", cfg_o, 8'h00);
		check("boot lock", {7'h00, lock_o}, 8'h00);
		put(1'b1, 1'b0, 1'b0, 8'h01);
		check("config without unlock", cfg_o, 8'h00);
		put(1'b1, 1'b0, 1'b1, 8'h01);
		check("config written", cfg_o, 8'h01);
		check("sync pending", {7'h00, pend}, 8'h01);
		waitfor(1'b0);
		waitfor(1'b1);
		clear(32);
		base = resets;
		repeat (7) clear(32);
		check("resets while cleared", resets - base, 8'h00);
		waitfor(1'b1);
		put(1'b1, 1'b0, 1'b1, 8'h11);
		waitfor(1'b0);
		base = resets;
		clear(40);
		clear(40);
		clear(100);
		clear(100);
		clear(100);
		check("window resets", resets - base, 8'h01);
		put(1'b0, 1'b1, 1'b0, 8'h01);
		check("lock without unlock", {7'h00, lock_o}, 8'h00);
		put(1'b0, 1'b1, 1'b1, 8'h01);
		check("lock set", {7'h00, lock_o}, 8'h01);
		put(1'b1, 1'b0, 1'b1, 8'h00);
		check("locked config", cfg_o, 8'h11);
		put(1'b0, 1'b1, 1'b1, 8'h00);
		check("lock clear outside debug", {7'h00, lock_o}, 8'h01);
		dbg = 1'b1;
		put(1'b0, 1'b1, 1'b1, 8'h00);
		dbg = 1'b0;
		check("lock clear in debug", {7'h00, lock_o}, 8'h00);
		put(1'b1, 1'b0, 1'b1, 8'h00);
		waitfor(1'b0);
		repeat (4) @(negedge clk_i);
		base = resets;
		repeat (300) @(negedge clk_i);
		check("resets when disabled", resets - base, 8'h00);
		fuse = 8'h03;
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (3) @(negedge clk_i);
		check("fuse config", cfg_o, 8'h03);
		check("fuse lock", {7'h00, lock_o}, 8'h01);
		conclude();
	end
endmodule
